// [hdl/vdei_top.sv]
/*
  event interrupt aggregator for the video decoder: detects changes of
  live conditions, keeps four 8-bit sticky status registers cleared by
  reads, gates them with per-flag enables onto an open-drain request pin.
  assumes all inputs synchronous to clk and the host read strobe to be a
  one-cycle pulse with a 2-bit register select.
*/
`timescale 1ns/100ps
module vdei_top
  import vdei_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // event sources
  input  wire logic                  power_fail_evt,
  input  wire logic                  scaler_err_evt,
  input  wire logic                  interlaced,
  input  wire logic                  hpll_locked,
  input  wire logic                  vlocked,
  input  wire logic                  field_60hz,
  input  wire logic                  capture_ready,
  input  wire logic [1:0]            colour_std,
  input  wire logic                  copy_prot_a,
  input  wire logic                  copy_prot_b,
  input  wire logic                  copy_prot_c,
  input  wire logic                  prog_service_id,
  input  wire logic                  widescreen_id,
  input  wire logic                  caption_id,
  // host side
  input  wire logic [VDEI_NFLAG-1:0] flag_enable_in,
  input  wire logic                  enable_wr,
  input  wire logic                  status_rd,
  input  wire logic [1:0]            status_sel,
  output logic      [VDEI_W-1:0]     status_data,
  output logic      [VDEI_NFLAG-1:0] flag_enable,
  output logic      [VDEI_NFLAG-1:0] pending_flags,
  output logic      [VDEI_W-1:0]     live_status,
  // open-drain request pin: output value and enable
  output logic                       irq_n_o,
  output logic                       irq_n_oe
);
  logic [VDEI_NFLAG-1:0] enable_reg;
  logic [VDEI_NFLAG-1:0] set_vec;
  logic [VDEI_NFLAG-1:0] flags;
  logic [VDEI_W-1:0]     status_data_reg;
  logic [VDEI_W-1:0]     live_reg;
  logic [10:0]           lvl;
  logic [10:0]           chg;
  logic                  irq_reg;
  logic [VDEI_W-1:0]     sel_byte;

  function automatic logic [VDEI_W-1:0] vdei_byte(
    input logic [VDEI_NFLAG-1:0] v,
    input logic [1:0]            sel
  );
    vdei_byte = v[sel*VDEI_W +: VDEI_W];
  endfunction

  // live levels that flag on any change in either direction
  assign lvl = {caption_id, widescreen_id, prog_service_id,
                copy_prot_c, copy_prot_b, copy_prot_a,
                colour_std, capture_ready, field_60hz, vlocked};

  logic hchg;
  logic ichg;

  vdei_change_det #(.W(11)) u_chg (
    .clk     (clk),
    .rst_n   (rst_n),
    .level   (lvl),
    .changed (chg)
  );

  vdei_change_det #(.W(2)) u_chg2 (
    .clk     (clk),
    .rst_n   (rst_n),
    .level   ({hpll_locked, interlaced}),
    .changed ({hchg, ichg})
  );

  always_comb begin
    set_vec                  = VDEI_RST_ZERO;
    set_vec[VDEI_B_POWER]    = power_fail_evt;
    set_vec[VDEI_B_SCALER]   = scaler_err_evt;
    set_vec[VDEI_B_INTERLACE_CHANGE_FLAG]     = ichg;
    set_vec[VDEI_B_HLOCK]    = hchg;
    set_vec[VDEI_B_VLOCK]    = chg[0];
    set_vec[VDEI_B_FIELD]    = chg[1];
    set_vec[VDEI_B_CAPRDY]   = chg[2];
    set_vec[VDEI_B_COLSTD]   = chg[3];
    set_vec[VDEI_B_COLSTD+1] = chg[4];
    set_vec[VDEI_B_COPY_A]   = chg[5];
    set_vec[VDEI_B_COPY_B]   = chg[6];
    set_vec[VDEI_B_COPY_C]   = chg[7];
    set_vec[VDEI_B_PSID]     = chg[8];
    set_vec[VDEI_B_WSID]     = chg[9];
    set_vec[VDEI_B_CCID]     = chg[10];
  end

  // four 8-bit banks, each cleared only by a read of itself
  genvar g;
  generate
    for (g = 0; g < VDEI_NREG; g++) begin : g_bank
      vdei_flag_bank u_bank (
        .clk    (clk),
        .rst_n  (rst_n),
        .set    (set_vec[g*VDEI_W +: VDEI_W]),
        .rd_clr (status_rd && status_sel == 2'(g)),
        .flags  (flags[g*VDEI_W +: VDEI_W])
      );
    end
  endgenerate

  // enables, all clear after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg <= VDEI_RST_ZERO;
    end else if (enable_wr) begin
      enable_reg <= flag_enable_in & VDEI_USED_MASK;
    end
  end

  // read data: the flags as they stand now, no capture at irq time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_data_reg <= '0;
    end else if (status_rd) begin
      status_data_reg <= vdei_byte(flags, status_sel);
    end
  end

  // live conditions byte, lets the host see the present state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live_reg <= '0;
    end else begin
      live_reg <= {1'b0, colour_std, capture_ready, field_60hz,
                   vlocked, hpll_locked, interlaced};
    end
  end

  // any enabled pending flag requests service
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & enable_reg);
    end
  end

  // pin only ever pulls low; released means not driven
  assign irq_n_o       = 1'b0;
  assign irq_n_oe      = irq_reg;
  assign status_data   = status_data_reg;
  assign flag_enable   = enable_reg;
  assign pending_flags = flags;
  assign live_status   = live_reg;
  // selected byte as it stands now, watched by the read assertion
  assign sel_byte      = vdei_byte(flags, status_sel);

  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    (|(flags & enable_reg)) |=> irq_n_oe)
    else $error("irq not asserted for enabled flag");
  a_irq_release: assert property (@(posedge clk) disable iff (!rst_n)
    !(|(flags & enable_reg)) |=> !irq_n_oe)
    else $error("irq held with no enabled flag");
  a_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    irq_n_o == 1'b0)
    else $error("open drain drives high");
  a_reset_enable: assert property (@(posedge clk)
    !rst_n |=> (enable_reg == '0))
    else $error("enable not cleared by reset");
  a_hlock_set: assert property (@(posedge clk) disable iff (!rst_n)
    hchg |=> flags[VDEI_B_HLOCK])
    else $error("hpll change not flagged");
  a_power_set: assert property (@(posedge clk) disable iff (!rst_n)
    power_fail_evt |=> flags[VDEI_B_POWER])
    else $error("power fail not flagged");
  a_other_read: assert property (@(posedge clk) disable iff (!rst_n)
    (flags[VDEI_B_INTERLACE_CHANGE_FLAG] && status_rd && status_sel != VDEI_REG_DEC)
      |=> flags[VDEI_B_INTERLACE_CHANGE_FLAG])
    else $error("other read cleared flag");
  a_read_live: assert property (@(posedge clk) disable iff (!rst_n)
    status_rd |=> status_data == $past(sel_byte))
    else $error("status read not live");

  c_irq_raise: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_n_oe));
  c_set_on_read: cover property (@(posedge clk) disable iff (!rst_n)
    status_rd && status_sel == VDEI_REG_COPY && set_vec[VDEI_B_COPY_A]);
  c_slice_clear: cover property (@(posedge clk) disable iff (!rst_n)
    flags[VDEI_B_CCID] && status_rd && status_sel == VDEI_REG_SLICE);
  c_power_irq: cover property (@(posedge clk) disable iff (!rst_n)
    flags[VDEI_B_POWER] && enable_reg[VDEI_B_POWER] && irq_n_oe);
endmodule

// [include/vdei_pkg.sv]
/*
  constants for the video decoder event interrupt block: status register
  indices, flag positions within the flat 32-bit vector, reset values.
  assumes a single 50 MHz core clock and synchronous active-low reset.
*/
// Functional notes
// - interrupt pin is open drain, pulled low while an interrupt is pending.
// - every flag has an enable of its own.
// - all enables are cleared by reset.
// - power fail during operation sets a flag; host must reprogram.
// - interlace versus progressive source change sets a flag.
// - horizontal pll lock change in either direction sets a flag.
// - vertical lock change in either direction sets a flag.
// - field rate change between 50 and 60 Hz sets a flag.
// - capture readiness change sets a flag.
// - two colour standard flags raised on standard change or colour loss.
// - three copy protection flags, each raised when its level changes.
// - slicer flags for service, widescreen and caption id found or lost.
// - scaler output formatting error sets a flag.
// - status reads return live conditions, not a frozen snapshot.
// - flags are grouped into four 8-bit status registers.
// - a flag clears only on a read of its own status register.
// - a trigger in the same cycle as the clearing read wins.
package vdei_pkg;
  localparam int         VDEI_NREG      = 4;
  localparam int         VDEI_W         = 8;
  localparam int         VDEI_NFLAG     = VDEI_NREG * VDEI_W;
  localparam logic [1:0] VDEI_REG_POWER = 2'h0;
  localparam logic [1:0] VDEI_REG_DEC   = 2'h1;
  localparam logic [1:0] VDEI_REG_COPY  = 2'h2;
  localparam logic [1:0] VDEI_REG_SLICE = 2'h3;
  // flag positions within the flat 32-bit vector (byte*8 + bit)
  localparam int VDEI_B_POWER    = 0;
  localparam int VDEI_B_SCALER   = 1;
  localparam int VDEI_B_INTERLACE_CHANGE_FLAG     = 8;
  localparam int VDEI_B_HLOCK    = 9;
  localparam int VDEI_B_VLOCK    = 10;
  localparam int VDEI_B_FIELD    = 11;
  localparam int VDEI_B_CAPRDY   = 12;
  localparam int VDEI_B_COLSTD   = 13;
  localparam int VDEI_B_COPY_A   = 16;
  localparam int VDEI_B_COPY_B   = 17;
  localparam int VDEI_B_COPY_C   = 18;
  localparam int VDEI_B_PSID     = 24;
  localparam int VDEI_B_WSID     = 25;
  localparam int VDEI_B_CCID     = 26;
  localparam logic [VDEI_NFLAG-1:0] VDEI_RST_ZERO = 32'h0000_0000;
  localparam logic [VDEI_NFLAG-1:0] VDEI_USED_MASK = 32'h0707_7F03;
endpackage

// [hdl/vdei_change_det.sv]
/*
  change detector: one-cycle pulse when a live level differs from last cycle.
  assumes inputs synchronous to clk; first cycle after reset gives no pulse.
*/
`timescale 1ns/100ps
module vdei_change_det #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] changed
);
  logic [W-1:0] prev_reg;
  logic         armed_reg;

  // arming avoids a spurious edge against the reset value of prev_reg
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg  <= '0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg  <= level;
      armed_reg <= 1'b1;
    end
  end

  assign changed = armed_reg ? (level ^ prev_reg) : '0;
endmodule

// [hdl/vdei_flag_bank.sv]
/*
  one 8-bit bank of sticky event flags with read-to-clear.
  assumes rd_clr is a one-cycle pulse for a read of this status register.
*/
`timescale 1ns/100ps
module vdei_flag_bank
  import vdei_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [VDEI_W-1:0] set,
  input  wire logic              rd_clr,
  output logic      [VDEI_W-1:0] flags
);
  logic [VDEI_W-1:0] flags_reg;
  logic [VDEI_W-1:0] flags_next;

  always_comb begin
    // set wins over the clearing read
    flags_next = (rd_clr ? '0 : flags_reg) | set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (set != '0) |=> ((flags_reg & $past(set)) == $past(set)))
    else $error("flag set lost");
  a_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_clr && set == '0) |=> (flags_reg == '0))
    else $error("read did not clear bank");
  a_hold_no_read: assert property (@(posedge clk) disable iff (!rst_n)
    (!rd_clr) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag dropped without read");
endmodule

// [testbench/vdei_host_model.sv]
/*
  host processor model: issues one-cycle status reads on request, captures
  the returned byte, and resolves the open-drain request pin with a pull-up.
  assumes the block answers a read one cycle after the edge that takes it.
*/
`timescale 1ns/100ps
module vdei_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rd_go,
  input  wire logic [1:0] rd_sel,
  input  wire logic [7:0] status_data,
  input  wire logic       irq_n_o,
  input  wire logic       irq_n_oe,
  output logic            status_rd,
  output logic      [1:0] status_sel,
  output logic      [7:0] rd_data,
  output logic            rd_done,
  output wire logic       irq_line
);
  logic busy_reg;
  logic wait_reg;
  // released pin floats up to the pull-up level
  assign irq_line = irq_n_oe ? irq_n_o : 1'h1;
  // only the register asked for is read, one read at a time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_rd  <= 1'h0;
      status_sel <= 2'h0;
      rd_data    <= 8'h00;
      rd_done    <= 1'h0;
      busy_reg   <= 1'h0;
      wait_reg   <= 1'h0;
    end else begin
      status_rd <= 1'h0;
      rd_done   <= 1'h0;
      if (!busy_reg && rd_go) begin
        status_rd  <= 1'h1;
        status_sel <= rd_sel;
        busy_reg   <= 1'h1;
        wait_reg   <= 1'h0;
      end else if (busy_reg && !wait_reg) begin
        wait_reg <= 1'h1;
      end else if (busy_reg) begin
        rd_data  <= status_data;
        rd_done  <= 1'h1;
        busy_reg <= 1'h0;
      end
    end
  end
endmodule

// [testbench/test_vdei_top.sv]
/*
  self-checking bench for the event interrupt block: toggles every event
  source both ways, enables flags one by one, reads and clears them.
  assumes the host model above and a 50 MHz clock.
*/
`timescale 1ns/100ps
module test_vdei_top;
  import vdei_pkg::*;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [14:0] src = 15'h0000;
  logic [31:0] en_in = 32'h0000_0000;
  logic        en_wr = 1'h0;
  logic        rd_go = 1'h0;
  logic [1:0]  rd_sel = 2'h0;
  logic        status_rd;
  logic [1:0]  status_sel;
  logic [7:0]  status_data;
  logic [31:0] flag_enable;
  logic [31:0] pending_flags;
  logic [7:0]  live_status;
  logic        irq_n_o;
  logic        irq_n_oe;
  logic [7:0]  rd_data;
  logic        rd_done;
  wire         irq_line;
  int          errors = 0;
  int          checked = 0;
  int          p;
  int          pos [15] = '{0, 1, 8, 9, 10, 11, 12, 13, 14, 16, 17, 18,
                            24, 25, 26};
  always #10 clk = ~clk;
  vdei_top u_vdei_top (.clk(clk), .rst_n(rst_n),
    .power_fail_evt(src[0]), .scaler_err_evt(src[1]),
    .interlaced(src[2]), .hpll_locked(src[3]), .vlocked(src[4]),
    .field_60hz(src[5]), .capture_ready(src[6]), .colour_std(src[8:7]),
    .copy_prot_a(src[9]), .copy_prot_b(src[10]), .copy_prot_c(src[11]),
    .prog_service_id(src[12]), .widescreen_id(src[13]),
    .caption_id(src[14]), .flag_enable_in(en_in), .enable_wr(en_wr),
    .status_rd(status_rd), .status_sel(status_sel),
    .status_data(status_data), .flag_enable(flag_enable),
    .pending_flags(pending_flags), .live_status(live_status),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  vdei_host_model u_vdei_host_model (.clk(clk), .rst_n(rst_n),
    .rd_go(rd_go), .rd_sel(rd_sel), .status_data(status_data),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .status_rd(status_rd),
    .status_sel(status_sel), .rd_data(rd_data), .rd_done(rd_done),
    .irq_line(irq_line));

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_en(input logic [31:0] v);
    en_in <= v;
    en_wr <= 1'h1;
    @(posedge clk);
    en_wr <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // hit raises a power-fail trigger on the very edge that takes the read
  task automatic rd(input logic [1:0] sel, input logic [7:0] exp,
                    input logic hit);
    int n;
    n = 0;
    rd_sel <= sel;
    rd_go <= 1'h1;
    @(posedge clk);
    rd_go <= 1'h0;
    if (hit) src[0] <= 1'h1;
    @(posedge clk);
    src[0] <= 1'h0;
    while (rd_done !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      $display("ERROR read_done expected 1 seen timeout");
      finish_test();
    end
    check("status_data", {24'h0, exp}, {24'h0, rd_data});
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    check("enable_reset", 32'h0, flag_enable);
    check("irq_idle", 32'h1, {31'h0, irq_line});
    for (int pass = 0; pass < 2; pass++) begin
      for (int k = 0; k < 15; k++) begin
        p = pos[k];
        src[k] <= (k < 2) ? 1'h1 : ~src[k];
        @(posedge clk);
        if (k < 2) src[k] <= 1'h0;
        repeat (3) @(posedge clk);
        check("pending_set", 32'h1 << p, pending_flags);
        check("irq_masked", 32'h1, {31'h0, irq_line});
        wr_en(32'h1 << p);
        check("irq_pending", 32'h0, {31'h0, irq_line});
        rd(p / 8, 8'h01 << (p % 8), 1'h0);
        check("pending_clr", 32'h0, pending_flags);
        check("irq_release", 32'h1, {31'h0, irq_line});
      end
    end
    src[0] <= 1'h1;
    @(posedge clk);
    src[0] <= 1'h0;
    wr_en(32'h0000_0001);
    rd(VDEI_REG_DEC, 8'h00, 1'h0);
    check("other_read", 32'h1, pending_flags);
    rd(VDEI_REG_POWER, 8'h01, 1'h1);
    check("set_wins", 32'h1, pending_flags);
    check("irq_held", 32'h0, {31'h0, irq_line});
    rd(VDEI_REG_POWER, 8'h01, 1'h0);
    check("irq_cleared", 32'h1, {31'h0, irq_line});
    wr_en(32'hFFFF_FFFF);
    check("enable_mask", VDEI_USED_MASK, flag_enable);
    src[2] <= 1'h1;
    src[4] <= 1'h1;
    src[8] <= 1'h1;
    repeat (4) @(posedge clk);
    check("live", 32'h45, {24'h0, live_status});
    check("irq_any", 32'h0, {31'h0, irq_line});
    rd(VDEI_REG_SLICE, 8'h00, 1'h0);
    check("slice_read", 32'h0000_4500, pending_flags);
    rd(VDEI_REG_DEC, 8'h45, 1'h0);
    check("irq_all_clr", 32'h1, {31'h0, irq_line});
    finish_test();
  end
endmodule
